/* phy_interrupt_and_ext_control_tb_top.sv */
/* Self-checking bench for the register block.
   Assumes pic_ctrl, pic_evt_src and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module phy_interrupt_and_ext_control_tb_top;
    localparam logic [7:0] A_C1 = {pic_pkg::IDX_EXT_CTRL_ONE, 2'h0};
    localparam logic [7:0] A_C2 = {pic_pkg::IDX_EXT_CTRL_TWO, 2'h0};
    localparam logic [7:0] A_MK = {pic_pkg::IDX_INT_MASK, 2'h0};
    localparam logic [7:0] A_ST = {pic_pkg::IDX_INT_STATUS, 2'h0};
    localparam logic [7:0] A_SS = {pic_pkg::IDX_SYS_STATUS, 2'h0};
    localparam logic [7:0] A_SE = {pic_pkg::IDX_SYS_ENABLE, 2'h0};
    localparam logic [7:0] A_SC = {pic_pkg::IDX_SYS_CLEAR, 2'h0};
    localparam logic [1:0] OK = pic_pkg::RESP_OKAY;
    localparam logic [1:0] ER = pic_pkg::RESP_SLVERR;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h3;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, far_end_loopback, cable_loopback, phy_int, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, jumbo_sel;
    logic [2:0] edge_rate;
    logic [15:0] src_event;
    int error_cnt = 0;
    int n_tests = 0;
    always #25 aclk = ~aclk;
    pic_ctrl #(.ADDR_W(8)) i_dut (.*);
    pic_evt_src i_ev (.*);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chb(input logic b, input logic e);
        chk({31'h0, b}, {31'h0, e});
    endtask
    task wrs(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
             input logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, r});
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        wrs(a, d, 4'h3, OK);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, r});
    endtask
    task t_reset;
        rdc(A_C1, 32'h0, OK);
        rdc(A_C2, 32'h0, OK);
        rdc(A_MK, 32'h0, OK);
        rdc(A_ST, 32'h0, OK);
        rdc(8'h70, 32'h0, ER);
    endtask
    task t_ctrl;
        wr(A_C1, 16'hFFFF);
        rdc(A_C1, 32'h0008, OK);
        chb(far_end_loopback, 1'b1);
        wrs(8'h5D, 16'h0000, 4'h3, ER);
        wrs(8'h70, 16'hFFFF, 4'h3, ER);
        rdc(A_C1, 32'h0008, OK);
        for (int i = 0; i < 8; i++)
        begin
            wr(A_C2, {i[2:0], 7'h7F, i[1:0], 4'hF});
            rdc(A_C2, {16'h0, i[2:0], 7'h0, i[1:0], 4'h1}, OK);
            chk({29'h0, edge_rate}, {29'h0, i[2:0]});
            chk({30'h0, jumbo_sel}, {30'h0, i[1:0]});
        end
        rdc(A_SS, 32'h0002, OK);
        chb(cable_loopback, 1'b1);
        wr(A_C2, 16'h0000);
        chb(cable_loopback, 1'b0);
        wrs(A_C2, 16'hFFFF, 4'h2, OK);
        rdc(A_C2, 32'hE000, OK);
        wrs(A_C2, 16'h0011, 4'h1, OK);
        rdc(A_C2, 32'hE011, OK);
        wrs(A_C2, 16'h0000, 4'hC, OK);
        rdc(A_C2, 32'hE011, OK);
    endtask
    task t_mask;
        i_ev.pulse(16'h0003);
        rdc(A_ST, 32'h0, OK);
        wr(A_MK, 16'h0002);
        rdc(A_ST, 32'h0002, OK);
        rdc(A_ST, 32'h0, OK);
        wr(A_MK, 16'h0001);
        rdc(A_ST, 32'h0001, OK);
        wr(A_MK, 16'hFFFF);
        rdc(A_MK, 32'hFFBF, OK);
        i_ev.pulse(16'hFFFF);
        wr(A_ST, 16'h0000);
        rdc(A_ST, 32'hFFBF, OK);
        rdc(A_ST, 32'h0, OK);
        chb(phy_int, 1'b0);
    endtask
    task t_int;
        wr(A_MK, 16'h0000);
        i_ev.pulse(16'h2000);
        wr(A_MK, 16'h2000);
        rdc(A_ST, 32'h2000, OK);
        wr(A_MK, 16'hA000);
        chb(phy_int, 1'b0);
        wr(A_SC, 16'h0003);
        wr(A_SE, 16'h0001);
        i_ev.pulse(16'h2000);
        chb(phy_int, 1'b1);
        rdc(A_ST, 32'hA000, OK);
        chb(phy_int, 1'b0);
        chb(irq, 1'b1);
        wr(A_SC, 16'h0001);
        chb(irq, 1'b0);
        wr(A_SE, 16'h0000);
        i_ev.pulse(16'h2000);
        rdc(A_SS, 32'h0001, OK);
        chb(irq, 1'b0);
    endtask
    task t_rerun;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chb(phy_int, 1'b0);
        chb(cable_loopback, 1'b0);
        chk({29'h0, edge_rate}, 32'h0);
        rdc(A_C2, 32'h0, OK);
        rdc(A_MK, 32'h0, OK);
        wr(A_MK, 16'h2000);
        rdc(A_ST, 32'h0, OK);
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_ctrl;
        t_mask;
        t_int;
        t_rerun;
        wrap_up;
    end
    initial
    begin
        repeat (4000) @(posedge aclk);
        error_cnt++;
        wrap_up;
    end
endmodule // phy_interrupt_and_ext_control_tb_top
`default_nettype wire

/* pic_ctrl.sv */
/*
 * PHY extended control registers and masked interrupt mask/status pair,
 * reached over an AXI4-Lite slave port.
 * Assumes one clock, a synchronous active-low reset, and event inputs that
 * are synchronous single-cycle or level pulses from the PHY's own logic.
 */
// Functional notes
// - A status bit reads zero whenever its mask bit is clear.
// - Every source event is held pending inside even while masked.
// - Setting a mask bit over a pending event makes its status bit read set.
// - A status read clears only the pending events whose mask is set then.
// - The interrupt pin and status bit 15 need global enable and a source.
// - Mask bits 14 to 0 map the fixed sources and bit 6 is reserved.
// - Status bits share the mask layout and all of them reset to zero.
// - Bit 3 of control one is a far-end loopback enable, reset to zero.
// - Bit 0 of control two is a cable loopback enable, reset to zero.
// - Bits 5:4 of control two select the largest packet length.
// - Bits 15:13 of control two select the 100 Mb/s edge rate.
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl #(
    parameter int unsigned ADDR_W = 8
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic [15:0]          src_event,
    output logic                      far_end_loopback,
    output logic                      cable_loopback,
    output logic [1:0]                jumbo_sel,
    output logic [2:0]                edge_rate,
    output logic                      phy_int,
    output logic                      irq
);
    initial
    begin
        if (ADDR_W < 8)
            $error("pic_ctrl: ADDR_W must be at least 8.");
    end

    function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] a);
        reg_index = a[7:2];
    endfunction

    function automatic logic known(input logic [ADDR_W-1:0] a);
        logic [5:0] i;
        i = a[7:2];
        known = (a[1:0] == 2'h0) && ((ADDR_W == 8) || (a >> 8) == '0)
              && (i == pic_pkg::IDX_EXT_CTRL_ONE
               || i == pic_pkg::IDX_EXT_CTRL_TWO
               || i == pic_pkg::IDX_INT_MASK
               || i == pic_pkg::IDX_INT_STATUS
               || i == pic_pkg::IDX_SYS_STATUS
               || i == pic_pkg::IDX_SYS_ENABLE
               || i == pic_pkg::IDX_SYS_CLEAR);
    endfunction

    logic [15:0]       ext_one_q, ext_one_d;
    logic [15:0]       ext_two_q, ext_two_d;
    logic [15:0]       mask_q, mask_d;
    logic [15:0]       pend_q, pend_d;
    logic [1:0]        sys_stat_q, sys_stat_d;
    logic [1:0]        sys_en_q, sys_en_d;
    logic              summary_q;
    logic              aw_full_q, w_full_q, bvalid_q, rvalid_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic [1:0]        bresp_q, rresp_q;
    logic [31:0]       rdata_q;

    // Write path: address and data are taken independently, then applied.
    wire               aw_take = s_axi_awvalid && s_axi_awready;
    wire               w_take  = s_axi_wvalid && s_axi_wready;
    wire               wr_fire = aw_full_q && w_full_q && !bvalid_q;
    wire [5:0]         wr_idx  = reg_index(awaddr_q);
    wire               wr_ok   = known(awaddr_q);
    wire [15:0]        lane    = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire               wr_one  = wr_fire && wr_ok
                                 && wr_idx == pic_pkg::IDX_EXT_CTRL_ONE;
    wire               wr_two  = wr_fire && wr_ok
                                 && wr_idx == pic_pkg::IDX_EXT_CTRL_TWO;
    wire               wr_mask = wr_fire && wr_ok
                                 && wr_idx == pic_pkg::IDX_INT_MASK;
    wire               wr_sen  = wr_fire && wr_ok
                                 && wr_idx == pic_pkg::IDX_SYS_ENABLE;
    wire               wr_sclr = wr_fire && wr_ok
                                 && wr_idx == pic_pkg::IDX_SYS_CLEAR;

    // Read path: one read at a time, answered the cycle after the address.
    wire               ar_take = s_axi_arvalid && s_axi_arready;
    wire [5:0]         rd_idx  = reg_index(s_axi_araddr);
    wire               rd_ok   = known(s_axi_araddr);
    wire               rd_stat = ar_take && rd_ok
                                 && rd_idx == pic_pkg::IDX_INT_STATUS;

    // Status view of the pending events.
    wire [15:0]        shown   = pend_q & mask_q & pic_pkg::SRC_BITS;
    wire               summary = mask_q[pic_pkg::GLOBAL_EN_BIT]
                                 && (|shown);
    wire [15:0]        status  = shown
                                 | (16'(summary) << pic_pkg::SUMMARY_BIT);

    wire [15:0]        wr_val  = wdata_q[15:0];
    wire [1:0]         jumbo_w = wr_val[pic_pkg::JUMBO_LSB +: 2];
    wire               bad_jum = wr_two && wstrb_q[0]
                                 && jumbo_w == pic_pkg::JUMBO_RESERVED;

    assign ext_one_d = wr_one
        ? (ext_one_q & ~(lane & pic_pkg::EXT_ONE_WMASK))
          | (wr_val & lane & pic_pkg::EXT_ONE_WMASK)
        : ext_one_q;
    assign ext_two_d = wr_two
        ? (ext_two_q & ~(lane & pic_pkg::EXT_TWO_WMASK))
          | (wr_val & lane & pic_pkg::EXT_TWO_WMASK)
        : ext_two_q;
    assign mask_d = wr_mask
        ? (mask_q & ~(lane & pic_pkg::MASK_WMASK))
          | (wr_val & lane & pic_pkg::MASK_WMASK)
        : mask_q;

    // New events win over a clear in the same cycle.
    assign pend_d = (pend_q & ~(rd_stat ? mask_q : 16'h0000))
                    | (src_event & pic_pkg::SRC_BITS);

    wire [1:0]         sys_ev  = {bad_jum, summary && !summary_q};
    wire [1:0]         sys_clr = (wr_sclr && wstrb_q[0]) ? wr_val[1:0]
                                                         : 2'h0;
    assign sys_stat_d = (sys_stat_q & ~sys_clr) | sys_ev;
    assign sys_en_d   = (wr_sen && wstrb_q[0]) ? wr_val[1:0] : sys_en_q;

    wire [15:0]        rd_val =
        (rd_idx == pic_pkg::IDX_EXT_CTRL_ONE) ? ext_one_q :
        (rd_idx == pic_pkg::IDX_EXT_CTRL_TWO) ? ext_two_q :
        (rd_idx == pic_pkg::IDX_INT_MASK)     ? mask_q    :
        (rd_idx == pic_pkg::IDX_INT_STATUS)   ? status    :
        (rd_idx == pic_pkg::IDX_SYS_STATUS)   ? {14'h0000, sys_stat_q} :
        (rd_idx == pic_pkg::IDX_SYS_ENABLE)   ? {14'h0000, sys_en_q}   :
                                                16'h0000;

    // Each register keeps its own short process, all cleared by reset.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ext_one_q <= pic_pkg::REG_RESET;
        else
            ext_one_q <= ext_one_d;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ext_two_q <= pic_pkg::REG_RESET;
        else
            ext_two_q <= ext_two_d;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            mask_q <= pic_pkg::REG_RESET;
        else
            mask_q <= mask_d;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pend_q <= pic_pkg::REG_RESET;
        else
            pend_q <= pend_d;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            summary_q <= 1'b0;
        else
            summary_q <= summary;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sys_stat_q <= pic_pkg::SYS_RESET;
        else
            sys_stat_q <= sys_stat_d;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sys_en_q <= pic_pkg::SYS_RESET;
        else
            sys_en_q <= sys_en_d;
    end

    // The address is held from its take until the write is applied.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_q <= 1'b0;
            awaddr_q  <= '0;
        end
        else if (aw_take)
        begin
            aw_full_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end
        else if (wr_fire)
            aw_full_q <= 1'b0;
    end

    // The data and strobes are held the same way.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_full_q <= 1'b0;
            wdata_q  <= 32'h00000000;
            wstrb_q  <= 4'h0;
        end
        else if (w_take)
        begin
            w_full_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end
        else if (wr_fire)
            w_full_q <= 1'b0;
    end

    // The response stands until the master takes it.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= pic_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_ok ? pic_pkg::RESP_OKAY
                              : pic_pkg::RESP_SLVERR;
        end
        else if (bvalid_q && s_axi_bready)
            bvalid_q <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= pic_pkg::RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_q <= 1'b1;
            rdata_q  <= {16'h0000, rd_ok ? rd_val : 16'h0000};
            rresp_q  <= rd_ok ? pic_pkg::RESP_OKAY : pic_pkg::RESP_SLVERR;
        end
        else if (rvalid_q && s_axi_rready)
            rvalid_q <= 1'b0;
    end

    assign s_axi_awready    = !aw_full_q;
    assign s_axi_wready     = !w_full_q;
    assign s_axi_bvalid     = bvalid_q;
    assign s_axi_bresp      = bresp_q;
    assign s_axi_arready    = !rvalid_q;
    assign s_axi_rvalid     = rvalid_q;
    assign s_axi_rdata      = rdata_q;
    assign s_axi_rresp      = rresp_q;

    assign far_end_loopback = ext_one_q[pic_pkg::FAR_LOOP_BIT];
    assign cable_loopback   = ext_two_q[pic_pkg::CABLE_LOOP_BIT];
    assign jumbo_sel        = ext_two_q[pic_pkg::JUMBO_LSB +: 2];
    assign edge_rate        = ext_two_q[pic_pkg::EDGE_LSB +: 3];
    assign phy_int          = summary;
    assign irq              = |(sys_stat_q & sys_en_q);
endmodule // pic_ctrl
`default_nettype wire

/* pic_ctrl_props.sv */
/* Concurrent assertions on the ports of the register block.
   Assumes it is bound to every pic_ctrl instance. */
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [15:0] src_event,
    input wire logic        far_end_loopback,
    input wire logic        cable_loopback,
    input wire logic [1:0]  jumbo_sel,
    input wire logic [2:0]  edge_rate,
    input wire logic        phy_int
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_rst_quiet: assert property ($rose(aresetn) |->
        !{far_end_loopback, cable_loopback, jumbo_sel, edge_rate, phy_int})
        else $error("outputs not quiet after reset");
    a_int_rise: assert property ($rose(phy_int) |->
        $past(|(src_event & 16'h7FBF)) || $rose(s_axi_bvalid))
        else $error("interrupt rose without cause");
    a_int_fall: assert property ($fell(phy_int) |->
        $past(s_axi_arvalid && s_axi_arready) || $rose(s_axi_bvalid))
        else $error("interrupt fell without read or write");
    a_ctrl_hold: assert property (
        $changed({far_end_loopback, cable_loopback, jumbo_sel, edge_rate})
        |-> $rose(s_axi_bvalid)) else $error("control moved without write");
    a_rd_upper: assert property (s_axi_rvalid |->
        s_axi_rdata[31:16] == 16'h0000) else $error("upper read data set");
    a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read response late");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
endmodule // pic_ctrl_props
bind pic_ctrl pic_ctrl_props i_props (.*);
`default_nettype wire

/* pic_evt_src.sv */
/* Model of the PHY logic that raises interrupt causes.
   Assumes the bench calls pulse between bus cycles. */
`timescale 1ns/1ps
`default_nettype none
module pic_evt_src (
    input  wire logic        aclk,
    output var  logic [15:0] src_event
);
    initial src_event = 16'h0000;
    // Each cause lasts one cycle; the block must hold it pending.
    task pulse(input logic [15:0] b);
        @(posedge aclk);
        src_event <= b;
        @(posedge aclk);
        src_event <= 16'h0000;
        @(negedge aclk);
    endtask
endmodule // pic_evt_src
`default_nettype wire

/* pic_pkg.sv */
/*
 * Constants for the PHY interrupt and extended control register block.
 * The package assumes 32-bit AXI4-Lite data in which each register takes one
 * aligned word, and 16-bit registers that sit in the low half of that word.
 */
package pic_pkg;
    localparam int unsigned REG_W = 16;

    // Register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_EXT_CTRL_ONE = 6'h17;
    localparam logic [5:0] IDX_EXT_CTRL_TWO = 6'h18;
    localparam logic [5:0] IDX_INT_MASK     = 6'h19;
    localparam logic [5:0] IDX_INT_STATUS   = 6'h1A;
    localparam logic [5:0] IDX_SYS_STATUS   = 6'h20;
    localparam logic [5:0] IDX_SYS_ENABLE   = 6'h21;
    localparam logic [5:0] IDX_SYS_CLEAR    = 6'h22;

    // Field positions.
    localparam int unsigned FAR_LOOP_BIT   = 3;
    localparam int unsigned CABLE_LOOP_BIT = 0;
    localparam int unsigned JUMBO_LSB      = 4;
    localparam int unsigned EDGE_LSB       = 13;
    localparam int unsigned GLOBAL_EN_BIT  = 15;
    localparam int unsigned SUMMARY_BIT    = 15;

    // Writable bits of the control and mask registers, whose other bits read as zero, and the source bits.
    localparam logic [15:0] EXT_ONE_WMASK = 16'h0008;
    localparam logic [15:0] EXT_TWO_WMASK = 16'hE031;
    localparam logic [15:0] MASK_WMASK    = 16'hFFBF;
    localparam logic [15:0] SRC_BITS      = 16'h7FBF;

    localparam logic [1:0]  JUMBO_RESERVED = 2'h3;
    localparam logic [15:0] REG_RESET      = 16'h0000;

    // Bits of the system event register.
    localparam int unsigned SYS_W         = 2;
    localparam int unsigned SYS_INT_RISE  = 0;
    localparam int unsigned SYS_BAD_JUMBO = 1;
    localparam logic [1:0]  SYS_RESET     = 2'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
